// File: rtc_ctl_pkg.sv
// package: register map, field layout, types and format helpers
package rtc_ctl_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_SEC  = 6'h00;  // seconds field
    localparam logic [5:0] IDX_MIN  = 6'h02;  // minutes field
    localparam logic [5:0] IDX_HOUR = 6'h04;  // hours field
    localparam logic [5:0] IDX_HALM = 6'h05;  // hours alarm field
    localparam logic [5:0] IDX_CTL  = 6'h0b;  // time_format_interrupt_control
    localparam logic [5:0] IDX_FLG  = 6'h0c;  // event flags, clear on read
    localparam logic [5:0] IDX_AST  = 6'h10;  // aux sticky status, write one to clear
    localparam logic [5:0] IDX_AMSK = 6'h11;  // aux status mask

    // control register bit positions
    localparam int CTL_HOLD = 7;  // update hold
    localparam int CTL_PIE  = 6;  // periodic enable
    localparam int CTL_AIE  = 5;  // alarm enable
    localparam int CTL_UIE  = 4;  // update-ended enable
    localparam int CTL_BIN  = 2;  // 1 binary, 0 bcd
    localparam int CTL_H24  = 1;  // 1 24-hour, 0 12-hour
    localparam int CTL_DST  = 0;  // seasonal shift enable

    // flag register layout: request at 7, events at 6:4
    localparam int FLG_REQ = 7;
    localparam int FLG_LO  = 4;
    localparam int HOUR_PM = 7;   // am/pm bit of 12-hour form

    // aux status bit positions
    localparam int AST_SKIP   = 0;  // tick suppressed by hold
    localparam int AST_RESUME = 1;  // hold released

    // reset values and writable masks
    localparam logic [7:0] CTL_RST   = 8'h00;
    localparam logic [7:0] CTL_WMASK = 8'hf7;  // bit 3 reserved, reads zero
    localparam logic [2:0] FLG_RST   = 3'h0;
    localparam logic [1:0] AST_RST   = 2'h0;
    localparam logic [1:0] AMSK_RST  = 2'h0;
    localparam logic [7:0] HOURS_HALF = 8'h0c;  // twelve
    localparam logic [7:0] TEN        = 8'h0a;

    // counter field selectors on the write port
    localparam logic [1:0] SEL_SEC  = 2'h0;
    localparam logic [1:0] SEL_MIN  = 2'h1;
    localparam logic [1:0] SEL_HOUR = 2'h2;
    localparam logic [1:0] SEL_HALM = 2'h3;

    // bus answer state, gray along idle -> ack -> idle
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_st_t;

    // internal counter values, always binary 24-hour
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] halm;
    } time_t;

    // event strobes from the timebase and counters
    typedef struct packed {
        logic sec_tick;   // one-second timebase pulse
        logic per_evt;    // periodic tick
        logic alm_evt;    // alarm match
        logic upd_done;   // update completed
    } evt_t;

    // write request towards the counters
    typedef struct packed {
        logic       valid;
        logic [1:0] sel;
        logic [7:0] val;
    } cnt_wr_t;

    // whole state of the control block
    typedef struct packed {
        bus_st_t    bus;
        logic [31:0] rdata;
        logic [7:0] ctl;
        logic [2:0] flg;
        logic [1:0] ast;
        logic [1:0] amsk;
        logic       adv;
        cnt_wr_t    wr;
    } ctl_state_t;

    // binary 0..99 to packed bcd
    function automatic logic [7:0] bin2bcd(input logic [7:0] v);
        logic [7:0] t;
        logic [7:0] u;
        t = v / TEN;
        u = v - 8'(t * TEN);
        return {t[3:0], u[3:0]};
    endfunction

    // packed bcd to binary
    function automatic logic [7:0] bcd2bin(input logic [7:0] b);
        return 8'({4'h0, b[7:4]} * TEN) + {4'h0, b[3:0]};
    endfunction

endpackage

// File: rtc_fmt.sv
// presentation converter between internal binary and bus format
module rtc_fmt
    import rtc_ctl_pkg::*;
(
    // mode
    input  wire logic       bin_mode,
    input  wire logic       h24,
    input  wire logic       is_hour,
    // read path
    input  wire logic [7:0] rd_bin,
    output logic      [7:0] rd_ext,
    // write path
    input  wire logic [7:0] wr_ext,
    output logic      [7:0] wr_bin
);

    // internal value to bus form; counters stay 24-hour binary
    always_comb begin
        logic [7:0] h;
        logic       pm;
        logic [7:0] v;
        h  = rd_bin;
        pm = 1'b0;
        v  = 8'h00;
        // 12-hour: fold 0..23 onto 1..12 plus pm bit
        if (is_hour && !h24) begin
            pm = (rd_bin >= HOURS_HALF);
            h  = pm ? rd_bin - HOURS_HALF : rd_bin;
            if (h == 8'h00) begin
                h = HOURS_HALF;
            end
        end
        v = bin_mode ? h : bin2bcd(h);
        rd_ext = (is_hour && !h24) ? {pm, v[6:0]} : v;
    end

    // bus form to internal value
    always_comb begin
        logic [7:0] v;
        logic [7:0] b;
        v = (is_hour && !h24) ? {1'b0, wr_ext[6:0]} : wr_ext;
        b = bin_mode ? v : bcd2bin(v);
        // 12 am is hour zero, pm adds twelve except at noon
        if (is_hour && !h24) begin
            if (b == HOURS_HALF) begin
                b = 8'h00;
            end
            if (wr_ext[HOUR_PM]) begin
                b = b + HOURS_HALF;
            end
        end
        wr_bin = b;
    end

endmodule

// File: rtc_ctl.sv
// control register, event flags and interrupt of the calendar clock
//
// Notes on behaviour
// - hold bit stops one-second advances; clearing resumes
// - periodic enable gates periodic events onto interrupt
// - alarm enable gates alarm events onto interrupt
// - update-ended enable gates update completion onto interrupt
// - presentation bit: 1 binary, 0 bcd
// - hour bit: 1 24-hour, 0 12-hour with pm
// - seasonal bit enables automatic hour shifting
// - format bits convert only at bus access
// - request flag is any enabled event flag
// - flags record regardless; flag read clears them
module rtc_ctl
    import rtc_ctl_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // avalon-mm slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // timebase and counter events
    input  wire evt_t        evt,
    // counter values, binary 24-hour
    input  wire time_t       cnt_val,
    // counter control
    output logic             adv_pulse,
    output cnt_wr_t          cnt_wr,
    output logic             dst_en,
    // interrupt
    output logic             irq
);

    ctl_state_t s_r;    // registered state
    ctl_state_t s_nxt;  // next state

    logic [5:0] idx;       // word index of the access
    logic       aligned;   // low address bits zero
    logic       req;       // read or write pending
    logic       acc;       // request accepted this edge
    logic       is_hour;   // access targets an hour field
    logic [7:0] fld_bin;   // selected counter value
    logic [7:0] fld_ext;   // same value in bus form
    logic [7:0] wr_bin;    // written value in binary form
    logic       irq_req;   // combined event request
    logic [2:0] flg_en;    // event flags after enables

    // index hit on an aligned word
    function automatic logic hit(input logic [5:0] want);
        return aligned && (idx == want);
    endfunction

    // true when the index names a counter field
    function automatic logic is_fld(input logic [5:0] i);
        return (i == IDX_SEC) || (i == IDX_MIN) ||
               (i == IDX_HOUR) || (i == IDX_HALM);
    endfunction

    // address split
    assign idx     = address[7:2];
    assign aligned = (address[1:0] == 2'h0);
    assign req     = read || write;
    assign acc     = req && (s_r.bus == BUS_ACK);
    // spelled out: a continuous assign would not see the function's inner reads
    assign is_hour = aligned && ((idx == IDX_HOUR) || (idx == IDX_HALM));

    // counter field mux for reads
    always_comb begin
        if (hit(IDX_SEC)) begin
            fld_bin = cnt_val.sec;
        end else if (hit(IDX_MIN)) begin
            fld_bin = cnt_val.min;
        end else if (hit(IDX_HOUR)) begin
            fld_bin = cnt_val.hour;
        end else if (hit(IDX_HALM)) begin
            fld_bin = cnt_val.halm;
        end else begin
            fld_bin = 8'h00;
        end
    end

    // format conversion sits only on the bus path, so stored
    // counts never change when software flips the mode bits
    rtc_fmt u_fmt (
        .bin_mode (s_r.ctl[CTL_BIN]),
        .h24      (s_r.ctl[CTL_H24]),
        .is_hour  (is_hour),
        .rd_bin   (fld_bin),
        .rd_ext   (fld_ext),
        .wr_ext   (writedata[7:0]),
        .wr_bin   (wr_bin)
    );

    // event flags masked by their enables, bit order 6:4
    assign flg_en  = s_r.flg & s_r.ctl[CTL_PIE:CTL_UIE];
    assign irq_req = |flg_en;

    // next state
    always_comb begin
        logic [1:0] ast_set;  // aux events this cycle
        logic [2:0] flg_clr;  // flags cleared by a flag read
        logic [7:0] ctl_new;  // written control value
        s_nxt         = s_r;
        s_nxt.adv     = 1'b0;
        s_nxt.wr      = '0;
        ast_set       = 2'h0;
        flg_clr       = 3'h0;
        ctl_new       = s_r.ctl;

        // bus answer: one wait cycle, then accept
        case (s_r.bus)
            BUS_IDLE: begin
                if (req) begin
                    s_nxt.bus = BUS_ACK;
                    // read data sampled now, stands at the accept edge
                    if (hit(IDX_CTL)) begin
                        s_nxt.rdata = {24'h0, s_r.ctl};
                    end else if (hit(IDX_FLG)) begin
                        s_nxt.rdata = {24'h0, irq_req, s_r.flg, 4'h0};
                    end else if (hit(IDX_AST)) begin
                        s_nxt.rdata = {30'h0, s_r.ast};
                    end else if (hit(IDX_AMSK)) begin
                        s_nxt.rdata = {30'h0, s_r.amsk};
                    end else if (aligned && is_fld(idx)) begin
                        s_nxt.rdata = {24'h0, fld_ext};
                    end else begin
                        // unmapped reads answer zero
                        s_nxt.rdata = 32'h0;
                    end
                end
            end
            BUS_ACK: begin
                s_nxt.bus = BUS_IDLE;
            end
            default: begin
                s_nxt.bus = BUS_IDLE;
            end
        endcase

        // writes take effect at the accept edge only
        if (acc && write && byteenable[0]) begin
            if (hit(IDX_CTL)) begin
                ctl_new   = writedata[7:0] & CTL_WMASK;
                s_nxt.ctl = ctl_new;
                // hold released by software
                if (s_r.ctl[CTL_HOLD] && !ctl_new[CTL_HOLD]) begin
                    ast_set[AST_RESUME] = 1'b1;
                end
            end else if (hit(IDX_AMSK)) begin
                s_nxt.amsk = writedata[1:0];
            end else if (hit(IDX_AST)) begin
                // write one to clear
                s_nxt.ast = s_r.ast & ~writedata[1:0];
            end else if (aligned && is_fld(idx)) begin
                // converted to binary before reaching the counters
                s_nxt.wr.valid = 1'b1;
                s_nxt.wr.sel   = idx[2] ? (idx[0] ? SEL_HALM : SEL_HOUR)
                                        : (idx[1] ? SEL_MIN : SEL_SEC);
                s_nxt.wr.val   = wr_bin;
            end
        end

        // every flag read clears all flags; an event that lands on
        // the accept edge itself still survives, since set wins
        if (acc && read && hit(IDX_FLG)) begin
            flg_clr = 3'h7;
        end

        // events set flags whatever the enables; set beats clear
        s_nxt.flg = (s_r.flg & ~flg_clr) |
                    {evt.per_evt, evt.alm_evt, evt.upd_done};

        // one-second advance passes only while hold is clear
        s_nxt.adv = evt.sec_tick && !s_r.ctl[CTL_HOLD];
        if (evt.sec_tick && s_r.ctl[CTL_HOLD]) begin
            ast_set[AST_SKIP] = 1'b1;
        end

        // aux sticky status, set wins over a same-cycle clear
        s_nxt.ast = s_nxt.ast | ast_set;
    end

    // state register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r.bus   <= BUS_IDLE;
            s_r.rdata <= 32'h0;
            s_r.ctl   <= CTL_RST;
            s_r.flg   <= FLG_RST;
            s_r.ast   <= AST_RST;
            s_r.amsk  <= AMSK_RST;
            s_r.adv   <= 1'b0;
            s_r.wr    <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // bus outputs; waitrequest drops in the accept cycle
    assign readdata    = s_r.rdata;
    assign waitrequest = req && (s_r.bus != BUS_ACK);

    // counter control from flip-flops
    assign adv_pulse = s_r.adv;
    assign cnt_wr    = s_r.wr;
    // counters shift the hour on their stored dates while set
    assign dst_en    = s_r.ctl[CTL_DST];

    // interrupt holds until a flag read clears the flags; aux
    // status joins only when software unmasks it
    assign irq = irq_req || |(s_r.ast & s_r.amsk);

endmodule

// File: rtc_ctl_chk.sv
// assertion checker for the calendar clock control block, bound to its top
module rtc_ctl_chk
    import rtc_ctl_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    // register bus
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // events and counters
    input wire evt_t        evt,
    input wire time_t       cnt_val,
    input wire logic        adv_pulse,
    input wire cnt_wr_t     cnt_wr,
    input wire logic        dst_en,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;     // request accepted this cycle
    logic ctl_wr;  // accepted write of control
    logic fld_wr;  // accepted write of a counter field
    logic cause;   // something that may raise the interrupt
    logic hold_r;  // mirror of hold bit
    logic dst_r;   // mirror of seasonal bit
    logic [2:0] en_r;  // mirror of event enables
    assign acc = (read | write) & ~waitrequest;
    assign ctl_wr = acc & write & byteenable[0] & (address == 8'h2c);
    assign fld_wr = acc & write & byteenable[0] & (address inside {8'h00, 8'h08, 8'h10, 8'h14});
    assign cause = (evt != 4'h0) | (acc & write);
    // mirror the written control bits, since the block's state is hidden
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hold_r <= 1'b0;
            dst_r  <= 1'b0;
            en_r   <= 3'h0;
        end else if (ctl_wr) begin
            hold_r <= writedata[CTL_HOLD];
            dst_r  <= writedata[CTL_DST];
            en_r   <= writedata[CTL_PIE:CTL_UIE];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence req_s; $rose(read | write); endsequence
    sequence ans_s; waitrequest ##1 !waitrequest; endsequence
    wait_one_a: assert property (req_s |-> ans_s)
        else $error("bus answer not after one wait cycle");
    adv_run_a: assert property (evt.sec_tick && !hold_r |=> adv_pulse)
        else $error("advance missing after tick");
    adv_hold_a: assert property (evt.sec_tick && hold_r |=> !adv_pulse)
        else $error("advance while held");
    adv_cause_a: assert property (adv_pulse |-> $past(evt.sec_tick) && !$past(hold_r))
        else $error("advance without cause");
    dst_follow_a: assert property (ctl_wr |=> ##[0:1] (dst_en == dst_r))
        else $error("seasonal enable not following control");
    fld_wr_a: assert property (fld_wr |=> cnt_wr.valid ##1 !cnt_wr.valid)
        else $error("field write pulse wrong");
    wr_cause_a: assert property (cnt_wr.valid |-> $past(fld_wr))
        else $error("field write pulse without bus write");
    bad_addr_a: assert property (acc && read && address[1:0] != 2'h0 |-> readdata == 32'h0)
        else $error("misaligned read not zero");
    irq_rise_a: assert property ($rose(irq) |-> $past(cause))
        else $error("interrupt rose without event or write");
    flg_req_a: assert property (acc && read && address == 8'h30 |->
        readdata[7] == |(readdata[6:4] & en_r) && readdata[3:0] == 4'h0)
        else $error("request flag not the enabled event flags");
endmodule
bind rtc_ctl rtc_ctl_chk chk_u (.clock(clock), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .evt(evt), .cnt_val(cnt_val), .adv_pulse(adv_pulse),
    .cnt_wr(cnt_wr), .dst_en(dst_en), .irq(irq));

// File: rtc_ctl_tb_top.sv
// self-checking bench for the calendar clock control block
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (got), (exp)); end end
module rtc_ctl_tb_top
    import rtc_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, nrst, read, write;   // clock, reset, bus strobes
    logic [7:0]  address;                    // byte address
    logic [31:0] writedata, readdata, rd;    // bus data and last read
    logic [3:0]  byteenable;                 // byte lanes
    logic        waitrequest, adv_pulse, dst_en, irq;
    evt_t        evt;                        // event pulses
    time_t       cnt_val;                    // counter values
    cnt_wr_t     cnt_wr;                     // field write towards counters
    int          bad_count, n_compared;      // verdict counters

    rtc_ctl dut_u (.clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .evt(evt), .cnt_val(cnt_val), .adv_pulse(adv_pulse),
        .cnt_wr(cnt_wr), .dst_en(dst_en), .irq(irq));

    // one bus cycle; held until waitrequest is seen low at a rising edge
    // no cycle limit here: only the watchdog ends a wait that never ends
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= !wr;
        @(posedge clock);
        while (waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    // one-cycle event pulse; returns at the edge that samples it
    task automatic pulse(input logic [3:0] e);
        @(posedge clock);
        evt <= evt_t'(e);
        @(posedge clock);
        evt <= evt_t'(4'h0);
    endtask

    // reset values, reserved bit, byte lanes, unmapped places
    task automatic t_regs();
        bus(0, 8'h2c, 8'h00); `CHK(rd, 32'h0)
        bus(0, 8'h30, 8'h00); `CHK(rd, 32'h0)
        bus(1, 8'h2c, 8'hff); bus(0, 8'h2c, 8'h00); `CHK(rd, 32'hf7)
        byteenable <= 4'h0;
        bus(1, 8'h2c, 8'h00); bus(0, 8'h2c, 8'h00); `CHK(rd, 32'hf7)
        byteenable <= 4'h1;
        bus(0, 8'h2d, 8'h00); `CHK(rd, 32'h0)
        bus(0, 8'h48, 8'h00); `CHK(rd, 32'h0)
        bus(1, 8'h2c, 8'h00);
    endtask

    // hold stops advances; held tick raises masked aux interrupt
    task automatic t_hold();
        pulse(4'h8); @(posedge clock); `CHK(adv_pulse, 1'b1)
        bus(1, 8'h2c, 8'h80); pulse(4'h8); @(posedge clock); `CHK(adv_pulse, 1'b0)
        `CHK(irq, 1'b0)
        bus(1, 8'h44, 8'h01); @(posedge clock); `CHK(irq, 1'b1)
        bus(1, 8'h40, 8'h01); @(posedge clock); `CHK(irq, 1'b0)
        bus(1, 8'h44, 8'h00); bus(1, 8'h2c, 8'h00);
        pulse(4'h8); @(posedge clock); `CHK(adv_pulse, 1'b1)
    endtask

    // each event recorded always, gated onto irq by its enable
    task automatic t_irq();
        logic [7:0] en;
        for (int i = 0; i < 3; i++) begin
            en = 8'h40 >> i;
            bus(1, 8'h2c, 8'h00); pulse(4'h4 >> i); @(posedge clock);
            `CHK(irq, 1'b0)
            bus(0, 8'h30, 8'h00); `CHK(rd[7:0], en)
            bus(1, 8'h2c, en); pulse(4'h4 >> i); @(posedge clock);
            `CHK(irq, 1'b1)
            bus(0, 8'h30, 8'h00); `CHK(rd[7:0], en | 8'h80)
            @(posedge clock); `CHK(irq, 1'b0)
        end
    endtask

    // hour 15 read through every presentation mode; hour, alarm, second and minute 45 writes converted
    task automatic t_fmt();
        logic [7:0] m[4] = '{8'h06, 8'h02, 8'h00, 8'h04};
        logic [7:0] e[4] = '{8'h0f, 8'h15, 8'h83, 8'h83};
        for (int i = 0; i < 4; i++) begin
            bus(1, 8'h2c, m[i]); bus(0, 8'h10, 8'h00); `CHK(rd[7:0], e[i])
        end
        bus(1, 8'h10, 8'h83); @(posedge clock);
        `CHK(cnt_wr, cnt_wr_t'({1'b1, SEL_HOUR, 8'h0f}))
        bus(1, 8'h2c, 8'h00); bus(0, 8'h14, 8'h00); `CHK(rd[7:0], 8'h12)
        bus(1, 8'h14, 8'h92); @(posedge clock);
        `CHK(cnt_wr, cnt_wr_t'({1'b1, SEL_HALM, 8'h0c}))
        bus(1, 8'h00, 8'h12); @(posedge clock);
        `CHK(cnt_wr, cnt_wr_t'({1'b1, SEL_SEC, 8'h0c}))
        bus(1, 8'h2c, 8'h02); bus(1, 8'h08, 8'h45); @(posedge clock);
        `CHK(cnt_wr, cnt_wr_t'({1'b1, SEL_MIN, 8'h2d}))
    endtask

    // seasonal shift enable reaches the counters
    task automatic t_dst();
        bus(1, 8'h2c, 8'h01); repeat (2) @(posedge clock); `CHK(dst_en, 1'b1)
        bus(1, 8'h2c, 8'h00); repeat (2) @(posedge clock); `CHK(dst_en, 1'b0)
    endtask

    // reset in mid-run drops the interrupt and control, advances run again
    task automatic t_rst();
        bus(1, 8'h2c, 8'hf0); pulse(4'h4);
        @(posedge clock); `CHK(irq, 1'b1)
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK(irq, 1'b0)
        nrst <= 1'b1;
        bus(0, 8'h2c, 8'h00); `CHK(rd, 32'h0)
        bus(0, 8'h30, 8'h00); `CHK(rd, 32'h0)
        pulse(4'h8); @(posedge clock); `CHK(adv_pulse, 1'b1)
    endtask

    // single place where the run ends
    task automatic report_and_stop();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // free-running clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // watchdog, far beyond the two hundred or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        report_and_stop();
    end

    // main sequence
    initial begin
        nrst = 1'b0; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 32'h0;
        byteenable = 4'h1; evt = evt_t'(4'h0);
        cnt_val = '{sec: 8'h00, min: 8'h2d, hour: 8'h0f, halm: 8'h00};
        bad_count = 0; n_compared = 0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        t_regs(); t_hold(); t_irq(); t_fmt(); t_dst(); t_rst();
        report_and_stop();
    end
endmodule
